// ---- rtl/ots_debounce.sv ----
// Purpose: Dead-band comparator with on and off debounce in millisecond ticks.
// Assumes: tick is a one-cycle enable; thresholds stable while used.
// Notes:   Output changes only on a tick after the raw state held long enough.
`timescale 1ns/1ps
`default_nettype none
module ots_debounce (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Tick and settings.
  input  wire logic               tick,
  input  wire logic signed [15:0] err,
  input  wire logic        [15:0] band,
  input  wire logic        [15:0] on_delay,
  input  wire logic        [15:0] off_delay,
  // Debounced lock.
  output logic                    lock
);

  logic [15:0] mag;
  logic        raw;
  logic [15:0] cnt;

  // Window test on the magnitude of the error.
  always_comb begin
    mag = err[15] ? 16'(-err) : 16'(err);
    raw = (mag <= band);
  end

  // Count ticks the raw state disagrees with the output; flip at the delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 16'h0000;
      lock <= 1'b0;
    end else if (tick) begin
      if (raw == lock) begin
        cnt <= 16'h0000;
      end else if (cnt + 16'h0001 >= (raw ? on_delay : off_delay)) begin
        cnt  <= 16'h0000;
        lock <= raw;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ots_sequencer.sv ----
// Purpose: Open-transition transfer sequencer with lock supervision and APB registers.
// Assumes: Inputs synchronous to pclk; pclk at 200 MHz.
// Notes:   Delays count millisecond ticks from the transfer-go rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.svh"

module ots_sequencer (
  // APB slave.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Transfer commands.
  input  wire logic                    transfer_execute_cmd,
  input  wire logic                    to_grid_request,
  input  wire logic                    to_drive_request,
  input  wire ots_pkg::ots_error_t     lock_error,
  // Drive and contactor controls.
  output logic                         sync_enable,
  output logic                         modulation_stop,
  output ots_pkg::ots_contactor_t      contactor,
  output logic                         lock_acknowledge,
  output logic                         sequence_complete,
  output logic                         irq
);

  // Registers.
  logic [3:0]  ctrl;
  logic [31:0] prescale;
  logic [15:0] inv_stop_ms, up_byp_ms, up_out_ms, dn_byp_ms, dn_out_ms, complete_ms;
  logic [15:0] lock_acquire_limit, lock_hold_minimum;
  logic [15:0] frq_on, frq_off, ph_on, ph_off, frq_band, ph_band;
  logic [2:0]  irq_stat, irq_en;

  // Sequencing state.
  ots_pkg::ots_state_t state;
  logic        dir_grid;
  logic        go_q;
  logic [31:0] pre_cnt;
  logic        tick;
  logic [15:0] seq_ms, acq_ms, hold_ms;
  logic [10:0] byp_pulse_ms, out_pulse_ms;
  logic        byp_close_p, byp_open_p, out_close_p, out_open_p;
  logic        byp_hold, out_hold;
  logic        freq_lock, phase_lock, both_lock;
  logic        timeout_fault;
  logic        wr, rd_ok;
  logic [2:0]  ev;
  logic        mode_open;
  logic        go_rise;

  assign wr        = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign mode_open = (ctrl[1:0] == 2'(ots_pkg::OTS_MODE_OPEN));
  assign go_rise   = transfer_execute_cmd & ~go_q;
  assign both_lock = freq_lock & phase_lock;

  // Millisecond tick from the programmable prescaler.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (pre_cnt >= prescale) begin
      pre_cnt <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

  // Frequency lock comparator and debounce.
  ots_debounce u_freq (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick),
    .err       (lock_error.freq_err),
    .band      (frq_band),
    .on_delay  (frq_on),
    .off_delay (frq_off),
    .lock      (freq_lock)
  );

  // Phase lock comparator and debounce, band in degrees.
  ots_debounce u_phase (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick),
    .err       (lock_error.phase_err),
    .band      (ph_band),
    .on_delay  (ph_on),
    .off_delay (ph_off),
    .lock      (phase_lock)
  );

  // Request, lock supervision and transfer state machine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= ots_pkg::OTS_IDLE;
      dir_grid      <= 1'b1;
      go_q          <= 1'b0;
      acq_ms        <= 16'h0000;
      hold_ms       <= 16'h0000;
      seq_ms        <= 16'h0000;
      timeout_fault <= 1'b0;
    end else begin
      go_q <= transfer_execute_cmd;
      if (!mode_open) begin
        state <= ots_pkg::OTS_IDLE;
      end else begin
        unique case (state)
          ots_pkg::OTS_IDLE: begin
            if (to_grid_request | to_drive_request) begin
              dir_grid      <= to_grid_request;
              acq_ms        <= 16'h0000;
              hold_ms       <= 16'h0000;
              timeout_fault <= 1'b0;
              state         <= ots_pkg::OTS_ACQUIRE;
            end
          end
          ots_pkg::OTS_ACQUIRE: begin
            if (tick) begin
              acq_ms  <= acq_ms + 16'h0001;
              hold_ms <= both_lock ? hold_ms + 16'h0001 : 16'h0000;
              if (both_lock && hold_ms + 16'h0001 >= lock_hold_minimum) begin
                state <= ots_pkg::OTS_LOCKED;
              end else if (acq_ms + 16'h0001 >= lock_acquire_limit) begin
                timeout_fault <= 1'b1;
                state         <= ots_pkg::OTS_IDLE;
              end
            end
          end
          ots_pkg::OTS_LOCKED: begin
            if (!(to_grid_request | to_drive_request)) begin
              state <= ots_pkg::OTS_IDLE;
            end else if (go_rise) begin
              seq_ms <= 16'h0000;
              state  <= ots_pkg::OTS_RUN;
            end else if (tick && !both_lock) begin
              hold_ms <= 16'h0000;
              state   <= ots_pkg::OTS_ACQUIRE;
            end
          end
          ots_pkg::OTS_RUN: begin
            if (tick) begin
              if (seq_ms + 16'h0001 >= complete_ms) begin
                seq_ms <= 16'h0000;
                state  <= ots_pkg::OTS_IDLE;
              end else begin
                seq_ms <= seq_ms + 16'h0001;
              end
            end
          end
        endcase
      end
    end
  end

  // Sequence points reached on a tick inside a run.
  logic run_tick;
  logic hit_stop, hit_byp, hit_out, hit_done;
  assign run_tick = (state == ots_pkg::OTS_RUN) & tick;
  assign hit_stop = run_tick & (seq_ms + 16'h0001 == inv_stop_ms);
  assign hit_byp  = run_tick & (seq_ms + 16'h0001 == (dir_grid ? up_byp_ms : dn_byp_ms));
  assign hit_out  = run_tick & (seq_ms + 16'h0001 == (dir_grid ? up_out_ms : dn_out_ms));
  assign hit_done = run_tick & (seq_ms + 16'h0001 >= complete_ms);

  // Modulation stop and completion flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulation_stop   <= 1'b0;
      sequence_complete <= 1'b0;
    end else begin
      if (hit_stop && dir_grid) begin
        modulation_stop <= 1'b1;
      end else if (state == ots_pkg::OTS_ACQUIRE) begin
        modulation_stop <= 1'b0;
      end
      if (hit_done) begin
        sequence_complete <= 1'b1;
      end else if (state == ots_pkg::OTS_ACQUIRE) begin
        sequence_complete <= 1'b0;
      end
    end
  end

  // Maintained outputs; a timeout leaves them as they are.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp_hold <= 1'b0;
      out_hold <= 1'b0;
    end else begin
      if (hit_byp) begin
        byp_hold <= dir_grid;
      end
      if (hit_out) begin
        out_hold <= ~dir_grid;
      end
    end
  end

  // One-second latch and unlatch pulses, one timer per contactor.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp_pulse_ms <= 11'h000;
      out_pulse_ms <= 11'h000;
      byp_close_p  <= 1'b0;
      byp_open_p   <= 1'b0;
      out_close_p  <= 1'b0;
      out_open_p   <= 1'b0;
    end else begin
      if (hit_byp && ctrl[`OTS_CTRL_BYP_LATCH]) begin
        byp_pulse_ms <= `OTS_PULSE_TICKS;
        byp_close_p  <= dir_grid;
        byp_open_p   <= ~dir_grid;
      end else if (tick && byp_pulse_ms != 11'h000) begin
        byp_pulse_ms <= byp_pulse_ms - 11'h001;
        if (byp_pulse_ms == 11'h001) begin
          byp_close_p <= 1'b0;
          byp_open_p  <= 1'b0;
        end
      end
      if (hit_out && ctrl[`OTS_CTRL_OUT_LATCH]) begin
        out_pulse_ms <= `OTS_PULSE_TICKS;
        out_close_p  <= ~dir_grid;
        out_open_p   <= dir_grid;
      end else if (tick && out_pulse_ms != 11'h000) begin
        out_pulse_ms <= out_pulse_ms - 11'h001;
        if (out_pulse_ms == 11'h001) begin
          out_close_p <= 1'b0;
          out_open_p  <= 1'b0;
        end
      end
    end
  end

  // Contactor group; maintained outputs silent when latch style chosen.
  always_comb begin
    contactor.bypass_hold_out    = byp_hold & ~ctrl[`OTS_CTRL_BYP_LATCH];
    contactor.bypass_close_pulse = byp_close_p;
    contactor.bypass_open_pulse  = byp_open_p;
    contactor.output_hold_out    = out_hold & ~ctrl[`OTS_CTRL_OUT_LATCH];
    contactor.output_close_pulse = out_close_p;
    contactor.output_open_pulse  = out_open_p;
  end

  assign lock_acknowledge = (state == ots_pkg::OTS_LOCKED);
  assign sync_enable      = (state == ots_pkg::OTS_ACQUIRE) | (state == ots_pkg::OTS_LOCKED);

  // Events for the interrupt status register.
  logic ack_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= lock_acknowledge;
    end
  end
  assign ev[`OTS_IRQ_DONE]    = hit_done;
  // Mirrors the acquire branch except for its mode check, so an expiry on a tick with the mode not open also flags.
  assign ev[`OTS_IRQ_TIMEOUT] = (state == ots_pkg::OTS_ACQUIRE) & tick &
                                ~(both_lock & (hold_ms + 16'h0001 >= lock_hold_minimum)) &
                                (acq_ms + 16'h0001 >= lock_acquire_limit);
  assign ev[`OTS_IRQ_ACK]     = lock_acknowledge & ~ack_q;

  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && paddr == `OTS_IRQ_CLR_OFS) ? pwdata[2:0] : 3'h0)) | ev;
    end
  end
  assign irq = |(irq_stat & irq_en);

  // Register writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= 4'h0;
      irq_en             <= 3'h0;
      prescale           <= 32'(`OTS_PRESCALE_RST);
      inv_stop_ms        <= `OTS_DELAY_RST;
      up_byp_ms          <= `OTS_DELAY_RST;
      up_out_ms          <= `OTS_DELAY_RST;
      dn_byp_ms          <= `OTS_DELAY_RST;
      dn_out_ms          <= `OTS_DELAY_RST;
      complete_ms        <= `OTS_DELAY_RST;
      lock_acquire_limit <= `OTS_DELAY_RST;
      lock_hold_minimum  <= `OTS_DELAY_RST;
      frq_on             <= `OTS_DELAY_RST;
      frq_off            <= `OTS_DELAY_RST;
      ph_on              <= `OTS_DELAY_RST;
      ph_off             <= `OTS_DELAY_RST;
      frq_band           <= `OTS_DELAY_RST;
      ph_band            <= `OTS_DELAY_RST;
    end else if (wr) begin
      unique case (paddr)
        `OTS_CTRL_OFS:     ctrl               <= pwdata[3:0];
        `OTS_IRQ_EN_OFS:   irq_en             <= pwdata[2:0];
        `OTS_PRESCALE_OFS: prescale           <= pwdata;
        `OTS_INV_STOP_OFS: inv_stop_ms        <= pwdata[15:0];
        `OTS_UP_BYP_OFS:   up_byp_ms          <= pwdata[15:0];
        `OTS_UP_OUT_OFS:   up_out_ms          <= pwdata[15:0];
        `OTS_DN_BYP_OFS:   dn_byp_ms          <= pwdata[15:0];
        `OTS_DN_OUT_OFS:   dn_out_ms          <= pwdata[15:0];
        `OTS_COMPLETE_OFS: complete_ms        <= pwdata[15:0];
        `OTS_ACQ_LIM_OFS:  lock_acquire_limit <= pwdata[15:0];
        `OTS_HOLD_MIN_OFS: lock_hold_minimum  <= pwdata[15:0];
        `OTS_FRQ_ON_OFS:   frq_on             <= pwdata[15:0];
        `OTS_FRQ_OFF_OFS:  frq_off            <= pwdata[15:0];
        `OTS_PH_ON_OFS:    ph_on              <= pwdata[15:0];
        `OTS_PH_OFF_OFS:   ph_off             <= pwdata[15:0];
        `OTS_FRQ_BAND_OFS: frq_band           <= pwdata[15:0];
        `OTS_PH_BAND_OFS:  ph_band            <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero and flag an error.
  logic [31:0] rdata;
  always_comb begin
    rd_ok = 1'b1;
    unique case (paddr)
      `OTS_CTRL_OFS:     rdata = {28'h0, ctrl};
      `OTS_STATUS_OFS:   rdata = {24'h0, freq_lock, phase_lock, timeout_fault,
                                  sequence_complete, modulation_stop, lock_acknowledge,
                                  2'(state)};
      `OTS_IRQ_STAT_OFS: rdata = {29'h0, irq_stat};
      `OTS_IRQ_EN_OFS:   rdata = {29'h0, irq_en};
      `OTS_IRQ_CLR_OFS:  rdata = 32'h0;
      `OTS_PRESCALE_OFS: rdata = prescale;
      `OTS_INV_STOP_OFS: rdata = {16'h0, inv_stop_ms};
      `OTS_UP_BYP_OFS:   rdata = {16'h0, up_byp_ms};
      `OTS_UP_OUT_OFS:   rdata = {16'h0, up_out_ms};
      `OTS_DN_BYP_OFS:   rdata = {16'h0, dn_byp_ms};
      `OTS_DN_OUT_OFS:   rdata = {16'h0, dn_out_ms};
      `OTS_COMPLETE_OFS: rdata = {16'h0, complete_ms};
      `OTS_ACQ_LIM_OFS:  rdata = {16'h0, lock_acquire_limit};
      `OTS_HOLD_MIN_OFS: rdata = {16'h0, lock_hold_minimum};
      `OTS_FRQ_ON_OFS:   rdata = {16'h0, frq_on};
      `OTS_FRQ_OFF_OFS:  rdata = {16'h0, frq_off};
      `OTS_PH_ON_OFS:    rdata = {16'h0, ph_on};
      `OTS_PH_OFF_OFS:   rdata = {16'h0, ph_off};
      `OTS_FRQ_BAND_OFS: rdata = {16'h0, frq_band};
      `OTS_PH_BAND_OFS:  rdata = {16'h0, ph_band};
      default: begin
        rdata = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign prdata  = rdata;
  assign pslverr = psel & penable & ~rd_ok;

endmodule
`default_nettype wire

// ---- shared/ots_map.svh ----
// Purpose: Register offsets, reset values and timing counts for the transfer sequencer.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Delay registers count millisecond ticks.
`ifndef OTS_MAP_SVH
`define OTS_MAP_SVH

`define OTS_CTRL_OFS       12'h000
`define OTS_STATUS_OFS     12'h004
`define OTS_IRQ_STAT_OFS   12'h008
`define OTS_IRQ_EN_OFS     12'h00c
`define OTS_IRQ_CLR_OFS    12'h010
`define OTS_PRESCALE_OFS   12'h014
`define OTS_INV_STOP_OFS   12'h018
`define OTS_UP_BYP_OFS     12'h01c
`define OTS_UP_OUT_OFS     12'h020
`define OTS_DN_BYP_OFS     12'h024
`define OTS_DN_OUT_OFS     12'h028
`define OTS_COMPLETE_OFS   12'h02c
`define OTS_ACQ_LIM_OFS    12'h030
`define OTS_HOLD_MIN_OFS   12'h034
`define OTS_FRQ_ON_OFS     12'h038
`define OTS_FRQ_OFF_OFS    12'h03c
`define OTS_PH_ON_OFS      12'h040
`define OTS_PH_OFF_OFS     12'h044
`define OTS_FRQ_BAND_OFS   12'h048
`define OTS_PH_BAND_OFS    12'h04c

// Control register fields.
`define OTS_CTRL_MODE_LSB  0
`define OTS_CTRL_BYP_LATCH 2
`define OTS_CTRL_OUT_LATCH 3

// Interrupt bit positions.
`define OTS_IRQ_DONE       0
`define OTS_IRQ_TIMEOUT    1
`define OTS_IRQ_ACK        2

// Reset values.
`define OTS_PRESCALE_RST   32'h0003_0d3f
`define OTS_DELAY_RST      16'h0000

// Pulse length of latch and unlatch outputs.
`define OTS_PULSE_TICKS    11'h3e8

`endif

// ---- shared/ots_pkg.sv ----
// Purpose: Shared types for the transfer sequencer.
// Assumes: Included after ots_map.svh where offsets are needed.
// Notes:   Holds types only.
package ots_pkg;

  typedef enum logic [1:0] {
    OTS_MODE_OFF    = 2'h0,
    OTS_MODE_OPEN   = 2'h1,
    OTS_MODE_CLOSED = 2'h2
  } ots_mode_t;

  typedef enum logic [1:0] {
    OTS_IDLE,
    OTS_ACQUIRE,
    OTS_LOCKED,
    OTS_RUN
  } ots_state_t;

  // Contactor drive group.
  typedef struct packed {
    logic bypass_hold_out;
    logic bypass_close_pulse;
    logic bypass_open_pulse;
    logic output_hold_out;
    logic output_close_pulse;
    logic output_open_pulse;
  } ots_contactor_t;

  // Lock comparator inputs: signed errors in drive units.
  typedef struct packed {
    logic signed [15:0] freq_err;
    logic signed [15:0] phase_err;
  } ots_error_t;

endpackage

// ---- tb/ots_asserts.sv ----
// Purpose: Port checks for the transfer sequencer.
// Assumes: One clock domain; bound to ots_sequencer.
// Notes:   Pulse width is in cycles, so a tick is at least one cycle.
`timescale 1ns/1ps
`default_nettype none
module ots_asserts (
  // Clock, reset and bus.
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Sequence ports.
  input wire logic                    to_grid_request,
  input wire logic                    to_drive_request,
  input wire logic                    sync_enable,
  input wire logic                    modulation_stop,
  input wire ots_pkg::ots_contactor_t contactor,
  input wire logic                    lock_acknowledge,
  input wire logic                    sequence_complete
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] pulse_len;
  // Counts the close pulse, since a short pulse may fail to latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pulse_len <= 32'h0;
    else if (contactor.bypass_close_pulse)
      pulse_len <= pulse_len + 32'h1;
    else
      pulse_len <= 32'h0;
  end
  a_bus_no_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_ack_in_sync: assert property (lock_acknowledge |-> sync_enable)
    else $error("acknowledge without sync");
  a_ack_drops_req: assert property (
    lock_acknowledge && !to_grid_request && !to_drive_request |-> ##[1:2] !lock_acknowledge)
    else $error("acknowledge kept after request drop");
  a_sync_needs_req: assert property (
    $rose(sync_enable) |-> $past(to_grid_request) || $past(to_drive_request))
    else $error("sync without request");
  a_pulse_excl: assert property (
    !(contactor.bypass_close_pulse && contactor.bypass_open_pulse))
    else $error("close and open pulse together");
  a_hold_masked: assert property (
    !(contactor.output_hold_out && (contactor.output_close_pulse || contactor.output_open_pulse)))
    else $error("hold and pulse styles mixed");
  a_pulse_width: assert property ($fell(contactor.bypass_close_pulse) |-> pulse_len >= 1000)
    else $error("close pulse too short");
  a_stop_in_run: assert property ($rose(modulation_stop) |-> !lock_acknowledge)
    else $error("modulation stopped while acknowledging");
  a_complete_idle: assert property (
    $rose(sequence_complete) |-> !sync_enable && !lock_acknowledge)
    else $error("completion outside idle");
  c_ack: cover property ($rose(lock_acknowledge));
  c_pulse: cover property ($fell(contactor.bypass_close_pulse));
  c_done: cover property ($rose(sequence_complete));
endmodule
bind ots_sequencer ots_asserts u_ots_asserts (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .to_grid_request, .to_drive_request, .sync_enable, .modulation_stop,
  .contactor, .lock_acknowledge, .sequence_complete);
`default_nettype wire

// ---- tb/ots_plc_model.sv ----
// Purpose: External PLC and the two contactors.
// Assumes: The bench tells the contactor styles.
// Notes:   Go is given only on acknowledge.
`timescale 1ns/1ps
`default_nettype none
module ots_plc_model (
  // Clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Bench control.
  input  wire logic                    arm,
  input  wire logic                    byp_latch,
  input  wire logic                    out_latch,
  // Sequencer side.
  input  wire logic                    lock_acknowledge,
  input  wire logic                    sequence_complete,
  input  wire ots_pkg::ots_contactor_t contactor,
  output logic                         transfer_execute_cmd,
  output logic                         bypass_closed,
  output logic                         output_closed
);
  logic byp_mem;
  logic out_mem;
  // Go follows acknowledge and falls once the sequence ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      transfer_execute_cmd <= 1'b0;
    else if (sequence_complete || !arm)
      transfer_execute_cmd <= 1'b0;
    else if (lock_acknowledge)
      transfer_execute_cmd <= 1'b1;
  end
  // A latched contactor keeps its last pulse, so a lost pulse is never recovered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp_mem <= 1'b0;
      out_mem <= 1'b0;
    end else begin
      if (contactor.bypass_close_pulse)
        byp_mem <= 1'b1;
      else if (contactor.bypass_open_pulse)
        byp_mem <= 1'b0;
      if (contactor.output_close_pulse)
        out_mem <= 1'b1;
      else if (contactor.output_open_pulse)
        out_mem <= 1'b0;
    end
  end
  // A maintained contactor follows its coil.
  assign bypass_closed = byp_latch ? byp_mem : contactor.bypass_hold_out;
  assign output_closed = out_latch ? out_mem : contactor.output_hold_out;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Directed bench for the transfer sequencer.
// Assumes: Prescale 4 gives a tick every 5 cycles.
// Notes:   Points are judged within one tick of phase slack.
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.svh"
module testbench;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd_v;
  logic                    grid, drive, arm, bl, ol, sync, mstop, ack, done, irq, go;
  logic                    byp_c, out_c;
  ots_pkg::ots_error_t     err;
  ots_pkg::ots_contactor_t con;
  logic [10:0]             obs;
  int                      n_errors, n_compared, t0, t1;
  assign obs = {irq, go, ack, con, mstop, done};
  // Free running clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ots_sequencer u_ots_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .transfer_execute_cmd(go), .to_grid_request(grid),
    .to_drive_request(drive), .lock_error(err), .sync_enable(sync),
    .modulation_stop(mstop), .contactor(con), .lock_acknowledge(ack),
    .sequence_complete(done), .irq);
  ots_plc_model u_ots_plc_model (.pclk, .presetn, .arm, .byp_latch(bl), .out_latch(ol),
    .lock_acknowledge(ack), .sequence_complete(done), .contactor(con),
    .transfer_execute_cmd(go), .bypass_closed(byp_c), .output_closed(out_c));
  function automatic int now();
    return int'($realtime / 5.0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One APB transfer, entered just after a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_v = prdata;
    rd_e = pslverr;
    if (n >= 50) begin
      n_errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  // Waits, bounded, until an observed bit takes a value; sampled at the edge.
  task automatic wt(input int i, input logic v, output int t);
    int n;
    n = 0;
    while (obs[i] !== v) begin
      @(posedge pclk);
      n++;
      if (n > 20000) begin
        n_errors++;
        end_sim();
      end
    end
    t = now();
  endtask
  task automatic near(input int dt, input int d);
    chk(32'(dt >= 5 * d - 4 && dt <= 5 * d + 2), 32'h1);
  endtask
  task automatic t_regs();
    int cfg [14] = '{2, 4, 3, 2, 3, 6, 40, 3, 1, 1, 1, 1, 2, 2};
    rd(`OTS_PRESCALE_OFS, 32'h00030d3f);
    rd(`OTS_INV_STOP_OFS, 32'h0);
    rd(12'h0fc, 32'h0);
    chk(32'(rd_e), 32'h1);
    apb(1'b1, `OTS_PRESCALE_OFS, 32'h4);
    for (int i = 0; i < 14; i++)
      apb(1'b1, 12'(`OTS_INV_STOP_OFS + 4 * i), 32'(cfg[i]));
    rd(`OTS_COMPLETE_OFS, 32'h6);
    apb(1'b1, `OTS_CTRL_OFS, 32'h5);
    apb(1'b1, `OTS_IRQ_EN_OFS, 32'h7);
  endtask
  task automatic t_to_drive();
    t0 = now();
    drive <= 1'b1;
    arm <= 1'b1;
    wt(8, 1'b1, t1);
    chk(32'(t1 - t0 >= 11), 32'h1);
    wt(9, 1'b1, t0);
    wt(5, 1'b1, t1);
    near(t1 - t0, 2);
    wt(4, 1'b1, t1);
    near(t1 - t0, 3);
    wt(0, 1'b1, t1);
    near(t1 - t0, 6);
    drive <= 1'b0;
    arm <= 1'b0;
    chk(32'(mstop), 32'h0);
    wt(5, 1'b0, t1);
    near(t1 - t0, 1002);
    chk(32'({byp_c, out_c}), 32'h1);
  endtask
  task automatic t_to_grid();
    grid <= 1'b1;
    arm <= 1'b1;
    wt(9, 1'b1, t0);
    wt(1, 1'b1, t1);
    near(t1 - t0, 2);
    wt(4, 1'b0, t1);
    near(t1 - t0, 3);
    wt(6, 1'b1, t1);
    near(t1 - t0, 4);
    wt(0, 1'b1, t1);
    near(t1 - t0, 6);
    grid <= 1'b0;
    arm <= 1'b0;
    wt(6, 1'b0, t1);
    near(t1 - t0, 1004);
    chk(32'({byp_c, out_c}), 32'h2);
  endtask
  // Opposite styles: maintained bypass, latched output contactor.
  task automatic t_swap();
    apb(1'b1, `OTS_CTRL_OFS, 32'h9);
    {bl, ol, drive, arm} <= 4'h7;
    wt(9, 1'b1, t0);
    wt(7, 1'b0, t1);
    near(t1 - t0, 2);
    wt(3, 1'b1, t1);
    near(t1 - t0, 3);
    wt(0, 1'b1, t1);
    {drive, arm} <= 2'h0;
    wt(3, 1'b0, t1);
    near(t1 - t0, 1003);
    chk(32'({byp_c, out_c}), 32'h1);
    apb(1'b1, `OTS_CTRL_OFS, 32'h5);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 3; m += 2) begin
      apb(1'b1, `OTS_CTRL_OFS, 32'(m) | 32'h4);
      drive <= 1'b1;
      repeat (20) @(posedge pclk);
      chk(32'(sync), 32'h0);
      drive <= 1'b0;
      @(posedge pclk);
    end
    apb(1'b1, `OTS_CTRL_OFS, 32'h5);
  endtask
  task automatic t_timeout();
    err <= {16'h0100, 16'h0100};
    apb(1'b1, `OTS_IRQ_CLR_OFS, 32'h7);
    t0 = now();
    grid <= 1'b1;
    wt(10, 1'b1, t1);
    near(t1 - t0, 40);
    grid <= 1'b0;
    chk(32'(con), 32'h4);
    rd(`OTS_IRQ_STAT_OFS, 32'h2);
    apb(1'b1, `OTS_IRQ_EN_OFS, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, `OTS_IRQ_CLR_OFS, 32'h7);
    rd(`OTS_IRQ_STAT_OFS, 32'h0);
  endtask
  // Reset, then each scenario in turn.
  initial begin
    {psel, penable, pwrite, grid, drive, arm, ol} = 7'h00;
    bl = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    err = 32'h0;
    presetn = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_to_drive();
    t_to_grid();
    t_swap();
    t_modes();
    t_timeout();
    end_sim();
  end
endmodule
`default_nettype wire
